//--- shared/mode_control_pkg.sv
// Purpose: Shared constants and carriers for the CAN operating-mode control block.
// Assumes: Eight-bit control register written through the host port as a whole byte.
// Notes:   Reset value of the control register is 1110_0111 (unimplemented bit 3 reads zero).
package mode_control_pkg;

   // ----------------------------------------------------------------
   // Control register layout
   // ----------------------------------------------------------------
   localparam int          REG_WIDTH       = 8;
   localparam int          MODE_MSB        = 7;
   localparam int          MODE_LSB        = 5;
   localparam int          ABORT_BIT       = 4;
   localparam int          UNUSED_BIT      = 3;
   localparam int          CLK_EN_BIT      = 2;
   localparam int          DIV_MSB         = 1;
   localparam int          DIV_LSB         = 0;
   localparam logic [7:0]  CTRL_RESET      = 8'hE7;
   localparam logic [7:0]  CTRL_WRITE_MASK = 8'hF7;

   // ----------------------------------------------------------------
   // Mode encodings
   // ----------------------------------------------------------------
   localparam logic [2:0]  MODE_NORMAL     = 3'h0;
   localparam logic [2:0]  MODE_SLEEP      = 3'h1;
   localparam logic [2:0]  MODE_LOOPBACK   = 3'h2;
   localparam logic [2:0]  MODE_LISTEN     = 3'h3;
   localparam logic [2:0]  MODE_CONFIG     = 3'h4;

   // ----------------------------------------------------------------
   // Clock output divider
   // ----------------------------------------------------------------
   localparam int          DIV_CNT_WIDTH   = 3;

   typedef struct packed {
      logic [2:0] mode_request_field;
      logic       abort_all_transmit_bit;
      logic       clock_output_enable_bit;
      logic [1:0] clock_output_divider_field;
   } ctrl_fields_type;

   typedef struct packed {
      logic       transmit_enable;
      logic       bus_participant;
      logic       loopback_active;
      logic       sleep_active;
      logic       config_active;
      logic       abort_request;
   } mode_flags_type;

endpackage

//--- hw/clock_output_divider.sv
// Purpose: Divides the oscillator clock by 1, 2, 4 or 8 for the clock output pin.
// Assumes: Select may change at any time; changes take hold at a counter wrap.
// Notes:   Pin is two signals; enable is low while driving.
`timescale 1ns/10ps
module clock_output_divider
(
   input  wire logic                      clock_in,
   input  wire logic                      rst_in,
   input  wire logic                      enable_in,
   input  wire logic [1:0]                select_in,
   output logic                           clock_output_pin_out,
   output logic                           clock_output_pin_oe_n_out
);
   import mode_control_pkg::*;

   typedef struct packed {
      logic [DIV_CNT_WIDTH-1:0] count;
      logic [1:0]               select;
      logic                     level;
      logic                     oe_n;
   } div_state_type;

   div_state_type state_q;
   div_state_type state_d;

   always_comb
   begin
      state_d = state_q;
      state_d.oe_n = ~enable_in;
      state_d.count = state_q.count + 1'b1;
      if (state_q.select == 2'h0)
      begin
         state_d.count = '0;
      end
      // Half period is 2^(select-1) cycles; the select is only reloaded at a wrap so periods stay whole.
      // The shift stays below the counter width, so divide by eight cannot wrap to zero.
      if (state_q.select == 2'h0 ||
          state_q.count == DIV_CNT_WIDTH'((DIV_CNT_WIDTH'(1) << (state_q.select - 2'h1)) - DIV_CNT_WIDTH'(1)))
      begin
         state_d.count = '0;
         state_d.level = ~state_q.level;
         state_d.select = select_in;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         state_q <= '{count: '0, select: 2'h3, level: 1'b0, oe_n: 1'b0};
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Divide by one passes the oscillator straight through.
   assign clock_output_pin_out = (state_q.select == 2'h0) ? clock_in : state_q.level;
   assign clock_output_pin_oe_n_out = state_q.oe_n;
endmodule

//--- hw/can_mode_control.sv
// Purpose: Operating-mode request, abort request and clock output control register.
// Assumes: Host writes whole bytes; tx_pending_in comes from same-clock transmit logic.
// Notes:   Current mode is reported in operating_mode_status_field_out.
// Operation
// - Normal mode: monitor all frames, drive acknowledge and error frames.
// - Frames are transmitted only in normal mode.
// - Bits 7..5 select mode: 000 normal, 001 sleep, 010 loopback, 011 listen, 100 config.
// - Clock output enable low puts the clock pin in high impedance.
// - Bits 1..0 divide the clock output by 1, 2, 4 or 8.
// - After reset clock output is on, dividing by eight.
// - Mode change waits for pending transmissions; host confirms via status bits.
// - Reset enters configuration mode and clears the error counters.
`timescale 1ns/10ps
module can_mode_control
(
   input  wire logic                              clock_in,
   input  wire logic                              rst_in,
   input  wire logic                              ctrl_write_in,
   input  wire logic [mode_control_pkg::REG_WIDTH-1:0] ctrl_wdata_in,
   output logic [mode_control_pkg::REG_WIDTH-1:0] ctrl_rdata_out,
   input  wire logic                              tx_pending_in,
   output logic [2:0]                             operating_mode_status_field_out,
   output mode_control_pkg::mode_flags_type       mode_flags_out,
   output logic                                   error_counter_clear_out,
   output logic                                   clock_output_pin_out,
   output logic                                   clock_output_pin_oe_n_out
);
   import mode_control_pkg::*;

   typedef enum logic [4:0]
   {
      ST_CONFIG   = 5'h01,
      ST_NORMAL   = 5'h02,
      ST_SLEEP    = 5'h04,
      ST_LOOPBACK = 5'h08,
      ST_LISTEN   = 5'h10
   } mode_state_type;

   typedef struct packed {
      ctrl_fields_type ctrl;
      mode_state_type  mode;
      logic            clear_counters;
   } ctl_state_type;

   ctl_state_type state_q;
   ctl_state_type state_d;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic mode_state_type decode_mode(input logic [2:0] code, input mode_state_type hold);
      unique case (code)
         MODE_NORMAL:   decode_mode = ST_NORMAL;
         MODE_SLEEP:    decode_mode = ST_SLEEP;
         MODE_LOOPBACK: decode_mode = ST_LOOPBACK;
         MODE_LISTEN:   decode_mode = ST_LISTEN;
         MODE_CONFIG:   decode_mode = ST_CONFIG;
         default:       decode_mode = hold;
      endcase
   endfunction

   function automatic logic [2:0] encode_mode(input mode_state_type m);
      unique case (m)
         ST_NORMAL:   encode_mode = MODE_NORMAL;
         ST_SLEEP:    encode_mode = MODE_SLEEP;
         ST_LOOPBACK: encode_mode = MODE_LOOPBACK;
         ST_LISTEN:   encode_mode = MODE_LISTEN;
         ST_CONFIG:   encode_mode = MODE_CONFIG;
         default:     encode_mode = MODE_CONFIG;
      endcase
   endfunction

   // Bit 3 has no storage, so whatever the host writes there is dropped here.
   function automatic ctrl_fields_type unpack_ctrl(input logic [REG_WIDTH-1:0] wr_byte);
      logic [REG_WIDTH-1:0] masked;
      ctrl_fields_type      f;
      masked = wr_byte & CTRL_WRITE_MASK;
      f.mode_request_field = masked[MODE_MSB:MODE_LSB];
      f.abort_all_transmit_bit = masked[ABORT_BIT];
      f.clock_output_enable_bit = masked[CLK_EN_BIT];
      f.clock_output_divider_field = masked[DIV_MSB:DIV_LSB];
      return f;
   endfunction

   // The read value is rebuilt from the stored fields; bit 3 always reads zero.
   function automatic logic [REG_WIDTH-1:0] pack_ctrl(input ctrl_fields_type f);
      logic [REG_WIDTH-1:0] r;
      r = '0;
      r[MODE_MSB:MODE_LSB] = f.mode_request_field;
      r[ABORT_BIT] = f.abort_all_transmit_bit;
      r[CLK_EN_BIT] = f.clock_output_enable_bit;
      r[DIV_MSB:DIV_LSB] = f.clock_output_divider_field;
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Mode flag decoding
   // ----------------------------------------------------------------
   // Only normal mode may drive the bus. Every silent mode keeps both
   // bus-facing flags low, so queued frames stay queued and no acknowledge
   // or error frame leaves the device.
   function automatic mode_flags_type decode_flags(input mode_state_type m, input logic abort);
      mode_flags_type f;
      f = '0;
      f.abort_request = abort;
      unique case (m)
         ST_NORMAL:
         begin
            f.transmit_enable = 1'b1;
            f.bus_participant = 1'b1;
         end
         ST_SLEEP:
         begin
            f.sleep_active = 1'b1;
         end
         ST_LOOPBACK:
         begin
            f.loopback_active = 1'b1;
         end
         ST_LISTEN:
         begin
            f.bus_participant = 1'b0;
         end
         ST_CONFIG:
         begin
            f.config_active = 1'b1;
         end
         default:
         begin
            // A corrupted state word is treated as configuration, the safe silent mode.
            f.config_active = 1'b1;
         end
      endcase
      return f;
   endfunction

   // ----------------------------------------------------------------
   // Register and mode sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      state_d.clear_counters = 1'b0;
      if (ctrl_write_in)
      begin
         state_d.ctrl = unpack_ctrl(ctrl_wdata_in);
      end
      // The request is read from the stored field, so a write shows on the
      // read port one cycle before the mode itself can move.
      // The mode only moves once nothing is waiting to go out.
      if (!tx_pending_in)
      begin
         state_d.mode = decode_mode(state_q.ctrl.mode_request_field, state_q.mode);
         if (state_d.mode == ST_CONFIG && state_q.mode != ST_CONFIG)
         begin
            state_d.clear_counters = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         // The reset byte holds a request code outside the five modes, so the mode
         // stays in configuration until the host writes a defined code.
         state_q.ctrl           <= unpack_ctrl(CTRL_RESET);
         state_q.mode           <= ST_CONFIG;
         state_q.clear_counters <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign ctrl_rdata_out                  = pack_ctrl(state_q.ctrl);
   assign operating_mode_status_field_out = encode_mode(state_q.mode);
   // The abort request is a plain level; the transmit logic must drop its queue while it stands.
   assign mode_flags_out                  = decode_flags(state_q.mode, state_q.ctrl.abort_all_transmit_bit);
   assign error_counter_clear_out         = state_q.clear_counters;

   // ----------------------------------------------------------------
   // Clock output pin
   // ----------------------------------------------------------------
   // The divider reloads its select only at a wrap, so a host write never
   // shortens a high or low phase of the pin.

   clock_output_divider u_divider
   (
      .clock_in                  (clock_in),
      .rst_in                    (rst_in),
      .enable_in                 (state_q.ctrl.clock_output_enable_bit),
      .select_in                 (state_q.ctrl.clock_output_divider_field),
      .clock_output_pin_out      (clock_output_pin_out),
      .clock_output_pin_oe_n_out (clock_output_pin_oe_n_out)
   );
endmodule

//--- bench/tx_queue_model.sv
// Purpose: Transmit queue stand-in that keeps frames pending for a set number of cycles.
// Assumes: Same clock as the mode control block.
// Notes:   A length of zero answers at once with nothing pending.
`timescale 1ns/10ps
module tx_queue_model
(
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   input  wire logic       start_in,
   input  wire logic [7:0] length_in,
   output logic            tx_pending_out
);
   logic [7:0] left_q;
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         left_q <= 8'h00;
      else if (start_in)
         left_q <= length_in;
      else if (left_q != 8'h00)
         left_q <= left_q - 8'h01;
   end
   assign tx_pending_out = (left_q != 8'h00);
endmodule

//--- bench/can_mode_control_props.sv
// Purpose: Port-level assertions for the operating-mode control register.
// Assumes: One clock domain with synchronous active-high reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/10ps
module can_mode_control_props
(
   input wire logic                       clock_in,
   input wire logic                       rst_in,
   input wire logic                       ctrl_write_in,
   input wire logic [7:0]                 ctrl_wdata_in,
   input wire logic [7:0]                 ctrl_rdata_out,
   input wire logic                       tx_pending_in,
   input wire logic [2:0]                 operating_mode_status_field_out,
   input wire mode_control_pkg::mode_flags_type mode_flags_out,
   input wire logic                       error_counter_clear_out,
   input wire logic                       clock_output_pin_out,
   input wire logic                       clock_output_pin_oe_n_out
);
   import mode_control_pkg::*;
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   sequence s_mode_req;
      ctrl_write_in && (ctrl_wdata_in[7:5] <= MODE_CONFIG) && !tx_pending_in ##1 !tx_pending_in && !ctrl_write_in;
   endsequence
   a_mode_takes_effect: assert property (s_mode_req |=> operating_mode_status_field_out == $past(ctrl_wdata_in[7:5], 2))
      else $error("mode not taken");
   a_write_stores_byte: assert property (ctrl_write_in |=> ctrl_rdata_out == ($past(ctrl_wdata_in) & CTRL_WRITE_MASK))
      else $error("write not stored");
   a_pending_holds_mode: assert property (tx_pending_in |=> $stable(operating_mode_status_field_out))
      else $error("mode changed while pending");
   a_tx_only_normal: assert property (mode_flags_out.transmit_enable |-> operating_mode_status_field_out == MODE_NORMAL)
      else $error("transmit outside normal");
   a_normal_joins_bus: assert property (operating_mode_status_field_out == MODE_NORMAL |-> mode_flags_out.bus_participant)
      else $error("normal not participating");
   a_mode_code_legal: assert property (operating_mode_status_field_out <= MODE_CONFIG)
      else $error("illegal mode");
   a_abort_request_on: assert property (ctrl_write_in && ctrl_wdata_in[ABORT_BIT] ##1 !ctrl_write_in |-> ##[0:1] mode_flags_out.abort_request)
      else $error("abort not requested");
   a_oe_follows_enable: assert property (clock_output_pin_oe_n_out == !$past(ctrl_rdata_out[CLK_EN_BIT]))
      else $error("pin enable wrong");
   a_reset_state_config: assert property ($fell(rst_in) |-> operating_mode_status_field_out == MODE_CONFIG && ctrl_rdata_out == CTRL_RESET)
      else $error("reset state wrong");
   a_clear_one_cycle: assert property (error_counter_clear_out |=> !error_counter_clear_out)
      else $error("clear too long");
endmodule
bind can_mode_control can_mode_control_props can_mode_control_props_inst (.clock_in(clock_in), .rst_in(rst_in),
   .ctrl_write_in(ctrl_write_in), .ctrl_wdata_in(ctrl_wdata_in), .ctrl_rdata_out(ctrl_rdata_out),
   .tx_pending_in(tx_pending_in), .operating_mode_status_field_out(operating_mode_status_field_out),
   .mode_flags_out(mode_flags_out), .error_counter_clear_out(error_counter_clear_out),
   .clock_output_pin_out(clock_output_pin_out), .clock_output_pin_oe_n_out(clock_output_pin_oe_n_out));

//--- bench/tb_can_mode_control.sv
// Purpose: Self-checking bench for the operating-mode control register.
// Assumes: Random low five bits come from a fixed-seed shift register; the mode bits cycle 0 to 4.
// Notes:   Clock output edges are counted with one edge of slack.
`timescale 1ns/10ps
module tb_can_mode_control;
   import mode_control_pkg::*;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
   logic           clock_in = 0, rst_in = 1, wr = 0, go = 0, pend, pin, oe_n, clr;
   logic [7:0]     wd = 8'h00, rd, v, len = 8'h00;
   logic [2:0]     mode, exp_mode;
   logic [31:0]    lfsr = 32'hA7AE4575;
   mode_flags_type flags;
   int             checks_done = 0, bad_count = 0, edges = 0;
   can_mode_control can_mode_control_inst (.clock_in(clock_in), .rst_in(rst_in), .ctrl_write_in(wr), .ctrl_wdata_in(wd),
      .ctrl_rdata_out(rd), .tx_pending_in(pend), .operating_mode_status_field_out(mode), .mode_flags_out(flags),
      .error_counter_clear_out(clr), .clock_output_pin_out(pin), .clock_output_pin_oe_n_out(oe_n));
   tx_queue_model tx_queue_model_inst (.clock_in(clock_in), .rst_in(rst_in), .start_in(go), .length_in(len),
      .tx_pending_out(pend));
   initial forever #12.5 clock_in = ~clock_in;
   always @(posedge pin) edges++;
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic write_reg(input logic [7:0] d);
      @(posedge clock_in);
      wr <= 1'b1;
      wd <= d;
      @(posedge clock_in);
      wr <= 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #(25 * 3000);
      bad_count++;
      end_of_test;
   end
   initial
   begin
      repeat (8) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      #1;
      `CHK(rd, CTRL_RESET)
      `CHK(mode, MODE_CONFIG)
      `CHK(oe_n, 1'b0)
      `CHK(clr, 1'b0)
      `CHK(flags.config_active, 1'b1)
      $display("reset test done");
      exp_mode = MODE_CONFIG;
      for (int i = 0; i < 16; i++)
      begin
         lfsr = lfsr_next(lfsr);
         v = {3'(i % 5), lfsr[4:0]};
         write_reg(v);
         if (v[7:5] <= MODE_CONFIG)
            exp_mode = v[7:5];
         `CHK(rd, v & 8'hF7)
         `CHK(mode, exp_mode)
         `CHK(flags.transmit_enable, exp_mode == MODE_NORMAL)
         `CHK(flags.bus_participant, exp_mode == MODE_NORMAL)
         `CHK(flags.config_active, exp_mode == MODE_CONFIG)
         `CHK(flags.sleep_active, exp_mode == MODE_SLEEP)
         `CHK(flags.loopback_active, exp_mode == MODE_LOOPBACK)
         `CHK(flags.abort_request, v[4])
         `CHK(oe_n, ~v[2])
      end
      $display("mode code test done");
      write_reg(8'h04);
      @(posedge clock_in);
      go <= 1'b1;
      len <= 8'h14;
      @(posedge clock_in);
      go <= 1'b0;
      write_reg(8'h84);
      `CHK(mode, MODE_NORMAL)
      repeat (20) @(posedge clock_in);
      #1;
      `CHK(mode, MODE_CONFIG)
      $display("pending test done");
      for (int d = 0; d < 4; d++)
      begin
         write_reg(8'h84 | d[7:0]);
         repeat (8) @(posedge clock_in);
         edges = 0;
         repeat (64) @(posedge clock_in);
         `CHK((edges >= (64 >> d) - 1) && (edges <= (64 >> d) + 1), 1'b1)
      end
      $display("divider test done");
      end_of_test;
   end
endmodule
